// ===== logic/lpd_pkg.sv
// command sequencing constants for the low-power ddr device core
// assumes a 25 MHz system clock and a separate link clock at the pins
package lpd_pkg;
  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CLK_SYS_NS = 40;
  localparam int INIT_IDLE_US = 200;
  localparam int INIT_IDLE_CYC = (INIT_IDLE_US * 1000 + CLK_SYS_NS - 1) /
                                 CLK_SYS_NS;
  localparam int REFRESH_CYCLE_INTERVAL_NS = 70;
  localparam int REFRESH_CYC = (REFRESH_CYCLE_INTERVAL_NS + CLK_SYS_NS - 1)
                               / CLK_SYS_NS;
  localparam int SELF_REFRESH_EXIT_INTERVAL_NS = 120;
  localparam int SREF_EXIT_CYC = (SELF_REFRESH_EXIT_INTERVAL_NS +
                                  CLK_SYS_NS - 1) / CLK_SYS_NS;
  localparam int POWER_DOWN_EXIT_INTERVAL_CK = 1;
  localparam int PDN_EXIT_CYC = POWER_DOWN_EXIT_INTERVAL_CK;
  localparam int BURST_LEN = 4;
  localparam int READ_DRIVE_CYC = BURST_LEN / 2;
  // ------------------------------------------------------------
  // widths and fields
  // ------------------------------------------------------------
  localparam int LANES = 4;
  localparam int DQ_W = 32;
  localparam int ADDR_W = 13;
  localparam int BANK_W = 2;
  localparam int COL_W = 9;
  localparam int PRECHARGE_SELECT_BIT = 10;
  localparam int TMR_W = 13;
  localparam int ENTRY_W = BANK_W + COL_W + DQ_W + LANES;
  localparam int PKT_W = 4 + 2 + BANK_W + ADDR_W + LANES + DQ_W + LANES;
  // ------------------------------------------------------------
  // command codes {cs_b, ras_b, cas_b, we_b}
  // ------------------------------------------------------------
  localparam logic [3:0] CMD_LMR = 4'h0;
  localparam logic [3:0] CMD_REF = 4'h1;
  localparam logic [3:0] CMD_PRE = 4'h2;
  localparam logic [3:0] CMD_ACT = 4'h3;
  localparam logic [3:0] CMD_WR = 4'h4;
  localparam logic [3:0] CMD_RD = 4'h5;
  localparam logic [3:0] CMD_BST = 4'h6;
  localparam logic [3:0] CMD_NOP = 4'h7;
  // ------------------------------------------------------------
  // sequencer states
  // ------------------------------------------------------------
  typedef enum logic [7:0] {
    ST_INIT = 8'h01,
    ST_IDLE = 8'h02,
    ST_RFSH = 8'h04,
    ST_PDN_PRE = 8'h08,
    ST_PDN_ACT = 8'h10,
    ST_PDN_EXIT = 8'h20,
    ST_SREF = 8'h40,
    ST_SREF_EXIT = 8'h80
  } lpd_state_t;
endpackage

// ===== logic/lpd_skid_buf.sv
// two-entry buffer with valid and ready on both sides
// assumes one clock; output comes straight from the head register
`timescale 1ns/100ps
`default_nettype none
module lpd_skid_buf #(
  parameter int W = 8
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic ce,
  // fill side
  input wire logic inValid,
  output logic inReady,
  input wire logic [W-1:0] inData,
  // drain side
  output logic outValid,
  input wire logic outReady,
  output logic [W-1:0] outData
);
  logic [W-1:0] skid_r;
  logic skidFull_r;
  logic pop;
  logic push;

  assign pop = outValid && outReady;
  assign push = inValid && inReady;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      outValid <= 1'b0;
      outData <= '0;
    end else if (ce) begin
      if (!outValid || pop) begin
        outValid <= skidFull_r || push;
        if (skidFull_r) begin
          outData <= skid_r;
        end else if (push) begin
          outData <= inData;
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      skid_r <= '0;
      skidFull_r <= 1'b0;
      inReady <= 1'b1;
    end else if (ce) begin
      if (push && outValid && !pop && !skidFull_r) begin
        skid_r <= inData;
        skidFull_r <= 1'b1;
        inReady <= 1'b0;
      end else if (skidFull_r && pop) begin
        skidFull_r <= 1'b0;
        inReady <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ===== logic/lpd_cmd_seq.sv
// command sequencer of the low-power ddr device core
// assumes pins arrive on clkLink; sequencing runs on clk_sys
`timescale 1ns/100ps
`default_nettype none
module lpd_cmd_seq #(
  parameter int INIT_CYC = lpd_pkg::INIT_IDLE_CYC
) (
  // system clock
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic ce,
  // link pins
  input wire logic clkLink,
  input wire logic cke,
  input wire logic cs_b,
  input wire logic ras_b,
  input wire logic cas_b,
  input wire logic we_b,
  input wire logic [lpd_pkg::BANK_W-1:0] bankAddr,
  input wire logic [lpd_pkg::ADDR_W-1:0] addr,
  input wire logic [lpd_pkg::DQ_W-1:0] dqIn,
  input wire logic [lpd_pkg::LANES-1:0] laneStrobeIn,
  input wire logic [lpd_pkg::LANES-1:0] laneWriteMask,
  // pin drivers
  output logic [lpd_pkg::LANES-1:0] laneStrobeOe,
  output logic dqOe,
  // status
  output logic initDone,
  output logic pdPrecharge,
  output logic pdActive,
  output logic selfRefresh,
  output logic refreshBusy,
  output logic [3:0] openBanks,
  output logic autoPrecharge,
  output logic protocolErr,
  // write beats
  output logic wrValid,
  input wire logic wrReady,
  output logic [lpd_pkg::ENTRY_W-1:0] wrBeat
);
  // ------------------------------------------------------------
  // link domain: pin capture and packet hand-off
  // ------------------------------------------------------------
  localparam int PIN_W = 4 + 1 + lpd_pkg::BANK_W + lpd_pkg::ADDR_W +
                         lpd_pkg::DQ_W + 2 * lpd_pkg::LANES;
  // pins reset to deselect with cke high, so no false event follows reset
  localparam logic [PIN_W-1:0] PIN_IDLE = {4'hF, 1'b1,
                                           {(PIN_W-5){1'b0}}};
  logic [PIN_W-1:0] pinS1_r;
  logic [PIN_W-1:0] pinS2_r;
  logic ckePrevL_r;
  logic reqTgl_r;
  logic ackS1_r;
  logic ackS2_r;
  logic ackTgl_r;
  logic [lpd_pkg::PKT_W-1:0] pkt_r;
  logic [3:0] lCmd;
  logic lCke;
  logic lEvent;

  always_ff @(posedge clkLink or negedge rst_b) begin
    if (!rst_b) begin
      pinS1_r <= PIN_IDLE;
      pinS2_r <= PIN_IDLE;
      ackS1_r <= 1'b0;
      ackS2_r <= 1'b0;
    end else begin
      pinS1_r <= {cs_b, ras_b, cas_b, we_b, cke, bankAddr, addr, dqIn,
                  laneStrobeIn, laneWriteMask};
      pinS2_r <= pinS1_r;
      ackS1_r <= ackTgl_r;
      ackS2_r <= ackS1_r;
    end
  end

  // deselect folds into nop
  assign lCmd = pinS2_r[PIN_W-1] ? lpd_pkg::CMD_NOP :
                pinS2_r[PIN_W-1 -: 4];
  assign lCke = pinS2_r[PIN_W-5];
  assign lEvent = (lCmd != lpd_pkg::CMD_NOP) || (lCke != ckePrevL_r) ||
                  (pinS2_r[2*lpd_pkg::LANES-1 -: lpd_pkg::LANES] != '0);

  always_ff @(posedge clkLink or negedge rst_b) begin
    if (!rst_b) begin
      ckePrevL_r <= 1'b1;
      reqTgl_r <= 1'b0;
      pkt_r <= '0;
    end else if (lEvent && (reqTgl_r == ackS2_r)) begin
      ckePrevL_r <= lCke;
      reqTgl_r <= ~reqTgl_r;
      pkt_r <= {lCmd, ckePrevL_r, lCke, pinS2_r[PIN_W-6:0]};
    end
  end

  // ------------------------------------------------------------
  // system domain: packet receive
  // ------------------------------------------------------------
  logic reqS1_r;
  logic reqS2_r;
  logic pending;
  logic take;
  logic [3:0] pCmd;
  logic pCkePrev;
  logic pCke;
  logic [lpd_pkg::BANK_W-1:0] pBank;
  logic [lpd_pkg::ADDR_W-1:0] pAddr;
  logic [lpd_pkg::DQ_W-1:0] pDq;
  logic [lpd_pkg::LANES-1:0] pStrobe;
  logic [lpd_pkg::LANES-1:0] pMask;
  logic [lpd_pkg::LANES-1:0] pBe;
  logic pHasCmd;
  logic pCkeFall;
  logic pCkeRise;
  logic pSelBit;

  assign {pCmd, pCkePrev, pCke, pBank, pAddr, pDq, pStrobe, pMask} = pkt_r;
  assign pHasCmd = pCmd != lpd_pkg::CMD_NOP;
  assign pCkeFall = pCkePrev && !pCke;
  assign pCkeRise = !pCkePrev && pCke;
  assign pSelBit = pAddr[lpd_pkg::PRECHARGE_SELECT_BIT];
  assign pending = reqS2_r != ackTgl_r;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      reqS1_r <= 1'b0;
      reqS2_r <= 1'b0;
      ackTgl_r <= 1'b0;
    end else if (ce) begin
      reqS1_r <= reqTgl_r;
      reqS2_r <= reqS1_r;
      if (take) begin
        ackTgl_r <= reqS2_r;
      end
    end
  end

  // ------------------------------------------------------------
  // write burst and lane mapping
  // ------------------------------------------------------------
  lpd_pkg::lpd_state_t st_r;
  lpd_pkg::lpd_state_t st_nxt;
  logic wrBurst_r;
  logic wrAp_r;
  logic [1:0] beat_r;
  logic [lpd_pkg::BANK_W-1:0] wrBank_r;
  logic [lpd_pkg::COL_W-1:0] wrCol_r;
  logic [lpd_pkg::COL_W-1:0] beatCol;
  logic isBeat;
  logic pushValid;
  logic pushReady;
  logic [1:0] rdCnt_r;

  genvar gi;
  generate
    for (gi = 0; gi < lpd_pkg::LANES; gi++) begin : g_lane
      assign pBe[gi] = pStrobe[gi] && !pMask[gi];
    end
  endgenerate

  // beats outside a write burst are dropped
  assign isBeat = (pStrobe != '0) && wrBurst_r && (st_r == lpd_pkg::ST_IDLE);
  assign pushValid = pending && isBeat;
  assign take = pending && (!isBeat || pushReady);
  assign beatCol = {wrCol_r[lpd_pkg::COL_W-1:2], wrCol_r[1:0] + beat_r};

  lpd_skid_buf #(.W(lpd_pkg::ENTRY_W)) u_buf (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .ce(ce),
    .inValid(pushValid),
    .inReady(pushReady),
    .inData({wrBank_r, beatCol, pDq, pBe}),
    .outValid(wrValid),
    .outReady(wrReady),
    .outData(wrBeat)
  );

  // ------------------------------------------------------------
  // bank state and bursts
  // ------------------------------------------------------------
  logic cmdTake;
  logic [3:0] banksAfter;
  logic burstBusy;

  assign cmdTake = take && pHasCmd && (st_r == lpd_pkg::ST_IDLE);
  assign burstBusy = wrBurst_r || (rdCnt_r != 2'h0);

  always_comb begin
    banksAfter = openBanks;
    if (cmdTake && pCmd == lpd_pkg::CMD_ACT) begin
      banksAfter[pBank] = 1'b1;
    end else if (cmdTake && pCmd == lpd_pkg::CMD_PRE) begin
      if (pSelBit) begin
        banksAfter = 4'h0;
      end else begin
        banksAfter[pBank] = 1'b0;
      end
    end else if (take && isBeat && beat_r == 2'h3 && wrAp_r) begin
      // close row after the last beat
      banksAfter[wrBank_r] = 1'b0;
    end else if (cmdTake && pCmd == lpd_pkg::CMD_RD && pSelBit) begin
      banksAfter[pBank] = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      openBanks <= 4'h0;
      wrBurst_r <= 1'b0;
      wrAp_r <= 1'b0;
      beat_r <= 2'h0;
      wrBank_r <= '0;
      wrCol_r <= '0;
      rdCnt_r <= 2'h0;
      autoPrecharge <= 1'b0;
    end else if (ce) begin
      openBanks <= banksAfter;
      autoPrecharge <= 1'b0;
      if (rdCnt_r != 2'h0) begin
        rdCnt_r <= rdCnt_r - 2'h1;
      end
      if (take && isBeat) begin
        beat_r <= beat_r + 2'h1;
        if (beat_r == 2'h3) begin
          wrBurst_r <= 1'b0;
          autoPrecharge <= wrAp_r;
        end
      end
      if (cmdTake && pCmd == lpd_pkg::CMD_WR) begin
        wrBurst_r <= 1'b1;
        wrAp_r <= pSelBit;
        beat_r <= 2'h0;
        wrBank_r <= pBank;
        wrCol_r <= pAddr[lpd_pkg::COL_W-1:0];
      end else if (cmdTake && pCmd == lpd_pkg::CMD_RD) begin
        rdCnt_r <= 2'(lpd_pkg::READ_DRIVE_CYC);
        autoPrecharge <= pSelBit;
      end
    end
  end

  // ------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------
  logic [lpd_pkg::TMR_W-1:0] tmr_r;
  logic [lpd_pkg::TMR_W-1:0] tmr_nxt;
  logic err_nxt;

  always_comb begin
    st_nxt = st_r;
    tmr_nxt = (tmr_r != '0) ? tmr_r - 1'b1 : tmr_r;
    err_nxt = 1'b0;
    case (st_r)
      lpd_pkg::ST_INIT: begin
        err_nxt = take && pHasCmd;
        if (tmr_r == '0) begin
          st_nxt = lpd_pkg::ST_IDLE;
        end
      end
      lpd_pkg::ST_IDLE: begin
        if (take && pCkeFall && pCmd == lpd_pkg::CMD_REF) begin
          err_nxt = openBanks != 4'h0;
          st_nxt = lpd_pkg::ST_SREF;
        end else if (take && pCkeFall) begin
          err_nxt = burstBusy;
          st_nxt = (banksAfter == 4'h0) ? lpd_pkg::ST_PDN_PRE :
                   lpd_pkg::ST_PDN_ACT;
        end else if (cmdTake && pCmd == lpd_pkg::CMD_REF) begin
          err_nxt = openBanks != 4'h0;
          st_nxt = lpd_pkg::ST_RFSH;
          tmr_nxt = lpd_pkg::TMR_W'(lpd_pkg::REFRESH_CYC - 1);
        end
      end
      lpd_pkg::ST_RFSH: begin
        err_nxt = take && (pHasCmd || !pCke);
        if (tmr_r == '0) begin
          st_nxt = lpd_pkg::ST_IDLE;
        end
      end
      lpd_pkg::ST_PDN_PRE, lpd_pkg::ST_PDN_ACT: begin
        if (take && pCkeRise) begin
          st_nxt = lpd_pkg::ST_PDN_EXIT;
          tmr_nxt = lpd_pkg::TMR_W'(lpd_pkg::PDN_EXIT_CYC - 1);
        end
      end
      lpd_pkg::ST_PDN_EXIT, lpd_pkg::ST_SREF_EXIT: begin
        // no command inside the exit interval
        err_nxt = take && pHasCmd;
        if (tmr_r == '0) begin
          st_nxt = lpd_pkg::ST_IDLE;
        end
      end
      lpd_pkg::ST_SREF: begin
        if (take && pCkeRise) begin
          st_nxt = lpd_pkg::ST_SREF_EXIT;
          tmr_nxt = lpd_pkg::TMR_W'(lpd_pkg::SREF_EXIT_CYC - 1);
        end
      end
      default: begin
        st_nxt = lpd_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= lpd_pkg::ST_INIT;
      tmr_r <= lpd_pkg::TMR_W'(INIT_CYC - 1);
      protocolErr <= 1'b0;
      initDone <= 1'b0;
      pdPrecharge <= 1'b0;
      pdActive <= 1'b0;
      selfRefresh <= 1'b0;
      refreshBusy <= 1'b0;
    end else if (ce) begin
      st_r <= st_nxt;
      tmr_r <= tmr_nxt;
      protocolErr <= err_nxt;
      initDone <= st_nxt != lpd_pkg::ST_INIT;
      pdPrecharge <= st_nxt == lpd_pkg::ST_PDN_PRE;
      pdActive <= st_nxt == lpd_pkg::ST_PDN_ACT;
      selfRefresh <= st_nxt == lpd_pkg::ST_SREF;
      refreshBusy <= st_nxt == lpd_pkg::ST_RFSH;
    end
  end

  // outputs float outside read bursts and in refresh
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      laneStrobeOe <= '0;
      dqOe <= 1'b0;
    end else if (ce) begin
      dqOe <= (rdCnt_r != 2'h0) && (st_nxt == lpd_pkg::ST_IDLE);
      laneStrobeOe <= {lpd_pkg::LANES{(rdCnt_r != 2'h0) &&
                                      (st_nxt == lpd_pkg::ST_IDLE)}};
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  property p_refreshLen;
    @(posedge clk_sys) disable iff (!rst_b || !ce)
    $rose(refreshBusy) |-> refreshBusy[*2] ##1 !refreshBusy;
  endproperty
  a_refreshLen: assert property (p_refreshLen)
    else $error("refresh busy length wrong");

  property p_refreshFloat;
    @(posedge clk_sys) disable iff (!rst_b)
    refreshBusy |-> !dqOe && laneStrobeOe == '0;
  endproperty
  a_refreshFloat: assert property (p_refreshFloat)
    else $error("outputs driven during refresh");

  property p_pdKind;
    @(posedge clk_sys) disable iff (!rst_b)
    (pdActive |-> openBanks != 4'h0) and (pdPrecharge |-> openBanks == 4'h0);
  endproperty
  a_pdKind: assert property (p_pdKind)
    else $error("power-down kind does not match open rows");

  property p_preAll;
    @(posedge clk_sys) disable iff (!rst_b || !ce)
    (cmdTake && pCmd == lpd_pkg::CMD_PRE && pSelBit) |=> openBanks == 4'h0;
  endproperty
  a_preAll: assert property (p_preAll)
    else $error("precharge all left a bank open");

  property p_wrAutoPre;
    @(posedge clk_sys) disable iff (!rst_b || !ce)
    (take && isBeat && beat_r == 2'h3 && wrAp_r) |=>
      autoPrecharge && !openBanks[$past(wrBank_r)];
  endproperty
  a_wrAutoPre: assert property (p_wrAutoPre)
    else $error("auto precharge did not close the row");

  property p_srefHold;
    @(posedge clk_sys) disable iff (!rst_b || !ce)
    (st_r == lpd_pkg::ST_SREF && !(take && pCkeRise)) |=> selfRefresh;
  endproperty
  a_srefHold: assert property (p_srefHold)
    else $error("self refresh left with cke low");

  property p_laneMap;
    @(posedge clk_sys) disable iff (!rst_b || !ce)
    (pushValid && pushReady && !wrValid) |=>
      wrValid && wrBeat[lpd_pkg::LANES-1:0] == ($past(pStrobe) & ~$past(pMask));
  endproperty
  a_laneMap: assert property (p_laneMap)
    else $error("byte enable lane mapping wrong");

  property p_beatOrder;
    @(posedge clk_sys) disable iff (!rst_b || !ce)
    (cmdTake && pCmd == lpd_pkg::CMD_WR) |=>
      beatCol == $past(pAddr[lpd_pkg::COL_W-1:0]);
  endproperty
  a_beatOrder: assert property (p_beatOrder)
    else $error("beat column out of burst order");

  property p_srefEntryErr;
    @(posedge clk_sys) disable iff (!rst_b || !ce)
    (st_r == lpd_pkg::ST_IDLE && take && pCkeFall &&
     pCmd == lpd_pkg::CMD_REF && openBanks != 4'h0) |=> protocolErr;
  endproperty
  a_srefEntryErr: assert property (p_srefEntryErr)
    else $error("self refresh entry with open bank not flagged");
endmodule
`default_nettype wire

// ===== testbench/lpd_ctrl_model.sv
// controller model that drives the link pins on clkLink
// assumes the bench calls its tasks; the link clock runs free
`timescale 1ns/100ps
`default_nettype none
module lpd_ctrl_model (
  // link clock
  input wire logic clkLink,
  // command pins
  output logic cke,
  output logic cs_b,
  output logic ras_b,
  output logic cas_b,
  output logic we_b,
  output logic [1:0] bankAddr,
  output logic [12:0] addr,
  // data pins
  output logic [31:0] dqIn,
  output logic [3:0] laneStrobeIn,
  output logic [3:0] laneWriteMask
);
  initial begin
    cke = 1'b1;
    {cs_b, ras_b, cas_b, we_b} = lpd_pkg::CMD_NOP;
    bankAddr = 2'h0;
    addr = 13'h0000;
    dqIn = 32'h0000_0000;
    laneStrobeIn = 4'h0;
    laneWriteMask = 4'h0;
  end
  // nops only, spaced past row and recovery times
  task automatic gap();
    @(posedge clkLink);
    #1;
    {cs_b, ras_b, cas_b, we_b} = lpd_pkg::CMD_NOP;
    laneStrobeIn = 4'h0;
    dqIn = ~dqIn;
    addr = ~addr;
    repeat (7) @(posedge clkLink);
  endtask
  // cke is a held level, clock keeps running
  task automatic issue(input logic [3:0] c, input logic [1:0] b,
                       input logic [12:0] a, input logic k);
    @(posedge clkLink);
    #1;
    {cs_b, ras_b, cas_b, we_b} = c;
    bankAddr = b;
    addr = a;
    cke = k;
    gap();
  endtask
  task automatic beat(input logic [31:0] d, input logic [3:0] s,
                      input logic [3:0] m);
    @(posedge clkLink);
    #1;
    dqIn = d;
    laneStrobeIn = s;
    laneWriteMask = m;
    gap();
  endtask
endmodule
`default_nettype wire

// ===== testbench/lpd_cmd_seq_test.sv
// self-checking bench of the command sequencer
// assumes the controller model drives every link pin but clkLink, which the bench generates
`timescale 1ns/100ps
`default_nettype none
module lpd_cmd_seq_test;
  localparam int INIT_N = 40;
  localparam int FREEZE_N = 10;
  logic clk_sys, rst_b, ce, clkLink, wrReady;
  logic cke, cs_b, ras_b, cas_b, we_b;
  logic [1:0] bankAddr;
  logic [12:0] addr;
  logic [31:0] dqIn;
  logic [3:0] laneStrobeIn, laneWriteMask, laneStrobeOe, openBanks;
  logic dqOe, initDone, pdPrecharge, pdActive, selfRefresh, refreshBusy;
  logic autoPrecharge, protocolErr, wrValid;
  logic [lpd_pkg::ENTRY_W-1:0] wrBeat;
  logic [lpd_pkg::ENTRY_W-1:0] beats[$];
  logic [3:0] seen;
  int errCount, nChecks, cycles, relAt, doneAt, errPulses;

  lpd_cmd_seq #(.INIT_CYC(INIT_N)) i_lpd_cmd_seq (.clk_sys(clk_sys),
    .rst_b(rst_b), .ce(ce), .clkLink(clkLink), .cke(cke), .cs_b(cs_b),
    .ras_b(ras_b), .cas_b(cas_b), .we_b(we_b), .bankAddr(bankAddr),
    .addr(addr), .dqIn(dqIn), .laneStrobeIn(laneStrobeIn),
    .laneWriteMask(laneWriteMask), .laneStrobeOe(laneStrobeOe),
    .dqOe(dqOe), .initDone(initDone), .pdPrecharge(pdPrecharge),
    .pdActive(pdActive), .selfRefresh(selfRefresh),
    .refreshBusy(refreshBusy), .openBanks(openBanks),
    .autoPrecharge(autoPrecharge), .protocolErr(protocolErr),
    .wrValid(wrValid), .wrReady(wrReady), .wrBeat(wrBeat));
  lpd_ctrl_model i_lpd_ctrl_model (.clkLink(clkLink), .cke(cke),
    .cs_b(cs_b), .ras_b(ras_b), .cas_b(cas_b), .we_b(we_b),
    .bankAddr(bankAddr), .addr(addr), .dqIn(dqIn),
    .laneStrobeIn(laneStrobeIn), .laneWriteMask(laneWriteMask));

  // ------------------------------------------------------------
  // clocks and monitors
  // ------------------------------------------------------------
  always #20 clk_sys = ~clk_sys;
  always #24 clkLink = ~clkLink;
  always @(posedge clk_sys) begin
    cycles++;
    if (wrValid === 1'b1 && wrReady === 1'b1) beats.push_back(wrBeat);
    if (protocolErr === 1'b1) errPulses++;
    if (initDone === 1'b1 && doneAt == 0) doneAt = cycles;
    seen <= seen | {(dqOe | (|laneStrobeOe)) & (refreshBusy | selfRefresh),
                    dqOe & (&laneStrobeOe), autoPrecharge, refreshBusy};
    if (cycles == 20000) begin
      errCount++;
      stop_test();
    end
  end

  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    nChecks++;
    if (got !== exp) begin
      errCount++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmd(input logic [3:0] c, input logic [1:0] b,
                     input logic [12:0] a, input logic k);
    i_lpd_ctrl_model.issue(c, b, a, k);
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_init();
    int dt;
    cmd(lpd_pkg::CMD_ACT, 2'h3, 13'h0000, 1'b1);
    check(errPulses, 1);
    // ce low stalls the init timer
    @(posedge clk_sys);
    #1 ce = 1'b0;
    repeat (FREEZE_N) @(posedge clk_sys);
    #1 ce = 1'b1;
    repeat (60) @(posedge clk_sys);
    dt = doneAt - relAt - FREEZE_N;
    check(dt >= INIT_N && dt <= INIT_N + 2, 1);
    cmd(lpd_pkg::CMD_ACT, 2'h1, 13'h0055, 1'b1);
    check(openBanks, 4'h2);
    cmd(lpd_pkg::CMD_PRE, 2'h2, 13'h0400, 1'b1);
    check(openBanks, 4'h0);
  endtask
  task automatic t_write();
    logic [8:0] col;
    logic [3:0] s, m;
    col = 9'h0D6;
    @(posedge clk_sys);
    #1 wrReady = 1'b0;
    cmd(lpd_pkg::CMD_ACT, 2'h2, 13'h0123, 1'b1);
    cmd(lpd_pkg::CMD_WR, 2'h2, {4'h0, col}, 1'b1);
    for (int i = 0; i < 4; i++) begin
      s = (i == 3) ? 4'h5 : 4'hF;
      m = (i == 3) ? 4'h0 : 4'(1 << i);
      i_lpd_ctrl_model.beat(32'hA0B1_C2D3 ^ 32'(i), s, m);
      if (i == 1) begin
        check(wrValid, 1'b1);
        check(beats.size(), 0);
        @(posedge clk_sys);
        #1 wrReady = 1'b1;
        repeat (4) @(posedge clk_sys);
      end
    end
    repeat (6) @(posedge clk_sys);
    check(beats.size(), 4);
    for (int i = 0; i < 4 && i < beats.size(); i++) begin
      s = (i == 3) ? 4'h5 : 4'hF;
      m = (i == 3) ? 4'h0 : 4'(1 << i);
      check(beats[i], {2'h2, col[8:2], 2'(col[1:0] + i),
            32'hA0B1_C2D3 ^ 32'(i), s & ~m});
    end
    check(openBanks, 4'h4);
  endtask
  task automatic t_pd_read();
    cmd(lpd_pkg::CMD_NOP, 2'h0, 13'h0000, 1'b0);
    check({pdActive, pdPrecharge}, 2'b10);
    cmd(lpd_pkg::CMD_NOP, 2'h0, 13'h0000, 1'b1);
    check(pdActive, 1'b0);
    seen = 4'h0;
    cmd(lpd_pkg::CMD_RD, 2'h2, 13'h0404, 1'b1);
    check(seen[2:1], 2'b11);
    check(openBanks, 4'h0);
    cmd(lpd_pkg::CMD_NOP, 2'h0, 13'h0000, 1'b0);
    check({pdActive, pdPrecharge}, 2'b01);
    cmd(lpd_pkg::CMD_NOP, 2'h0, 13'h0000, 1'b1);
  endtask
  task automatic t_refresh();
    seen = 4'h0;
    cmd(lpd_pkg::CMD_REF, 2'h0, 13'h0000, 1'b1);
    check({seen[3], seen[0]}, 2'b01);
    cmd(lpd_pkg::CMD_ACT, 2'h0, 13'h0011, 1'b1);
    cmd(lpd_pkg::CMD_ACT, 2'h1, 13'h0022, 1'b1);
    check(openBanks, 4'h3);
    cmd(lpd_pkg::CMD_REF, 2'h0, 13'h0000, 1'b1);
    check(errPulses, 2);
    cmd(lpd_pkg::CMD_PRE, 2'h3, 13'h0400, 1'b1);
    check(openBanks, 4'h0);
  endtask
  task automatic t_self_refresh();
    seen = 4'h0;
    cmd(lpd_pkg::CMD_REF, 2'h0, 13'h0000, 1'b0);
    check(selfRefresh, 1'b1);
    repeat (20) @(posedge clkLink);
    check(selfRefresh, 1'b1);
    check(seen[3], 1'b0);
    cmd(lpd_pkg::CMD_NOP, 2'h0, 13'h0000, 1'b1);
    check(selfRefresh, 1'b0);
    check(errPulses, 2);
  endtask

  task automatic stop_test();
    if (errCount == 0 && nChecks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    clk_sys = 1'b0;
    clkLink = 1'b0;
    rst_b = 1'b0;
    ce = 1'b1;
    wrReady = 1'b1;
    seen = 4'h0;
    repeat (8) @(posedge clk_sys);
    #1 rst_b = 1'b1;
    relAt = cycles;
    t_init();
    t_write();
    t_pd_read();
    t_refresh();
    t_self_refresh();
    stop_test();
  end
endmodule
`default_nettype wire
